// ---- shared/diag_pkg.sv ----
// Purpose: constants and carriers for the field-bus diagnostic command controller
// Assumes: 32-bit classic wishbone register bus, byte addresses
// Notes: offsets are byte addresses
`default_nettype none
package diag_pkg;
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] STAT_OFS = 8'h04;
	localparam logic [7:0] TBL_START_OFS = 8'h08;
	localparam logic [7:0] TBL_LEN_OFS = 8'h0c;
	localparam logic [7:0] COUNT_OFS = 8'h10;
	localparam logic [7:0] IRQ_STAT_OFS = 8'h14;
	localparam logic [7:0] IRQ_MASK_OFS = 8'h18;
	localparam logic [7:0] DEV_MASK_OFS = 8'h1c;
	// control bits
	localparam int PULSE_BIT = 0;
	localparam int CLEAR_BIT = 1;
	localparam int LOG_BIT = 2;
	localparam int ENABLE_BIT = 3;
	// status bits
	localparam int SETUP_ERR_BIT = 0;
	localparam int OVERFLOW_BIT = 1;
	localparam int BUSY_BIT = 2;
	// interrupt event bits
	localparam int EV_CLEAR_DONE = 0;
	localparam int EV_PULSE_DONE = 1;
	localparam int EV_SETUP_ERR = 2;
	localparam int EV_LOGGED = 3;
	localparam int EV_W = 4;
	localparam logic [15:0] TBL_START_RST = 16'h0000;
	localparam logic [15:0] TBL_LEN_RST = 16'h0000;
	localparam logic [15:0] TBL_LEN_MAX = 16'h0010;
	localparam int SWEEP_CYCLES_DEF = 64;

	typedef enum logic [1:0] {CMD_NONE, CMD_CLEAR, CMD_PULSE} bcast_cmd_t;
	typedef struct packed {
		logic valid;
		bcast_cmd_t cmd;
		logic [4:0] dev;
	} datagram_t;
	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [7:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} wb_req_t;
endpackage
`default_nettype wire

// ---- verilog/sweep_timer.sv ----
// Purpose: produces one-cycle sweep ticks
// Assumes: single clock
// Notes: period is a parameter
`default_nettype none
module sweep_timer import diag_pkg::*; #(
	parameter int SWEEP_CYCLES = SWEEP_CYCLES_DEF
) (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	output logic tick_o
);
	typedef struct packed {
		logic [15:0] cnt;
		logic tick;
	} st_t;
	st_t q, d;
	// period must fit the 16-bit counter
	if (SWEEP_CYCLES < 2 || SWEEP_CYCLES > 65535) begin : g_bad_period
		$error("sweep_timer: bad SWEEP_CYCLES");
	end
	always_comb begin
		d = q;
		d.tick = 1'b0;
		if (q.cnt == 16'(SWEEP_CYCLES - 1)) begin
			d.cnt = 16'h0000;
			d.tick = 1'b1;
		end else begin
			d.cnt = q.cnt + 16'h0001;
		end
	end
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end
	assign tick_o = q.tick;
endmodule // sweep_timer
`default_nettype wire

// ---- verilog/bcast_sender.sv ----
// Purpose: walks the logged-in devices, one datagram per unit per sweep
// Assumes: start only when idle
// Notes: done pulses in the same cycle as the last device's datagram
`default_nettype none
module bcast_sender import diag_pkg::*; #(
	parameter int NUM_UNITS = 2,
	parameter int DEVS = 32
) (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic start_i,
	input wire bcast_cmd_t cmd_i,
	input wire logic sweep_i,
	input wire logic [DEVS-1:0] logged_in_i,
	output datagram_t [NUM_UNITS-1:0] dgram_o,
	output logic busy_o,
	output logic done_o
);
	localparam int PER = DEVS / NUM_UNITS;
	typedef struct packed {
		logic busy;
		logic done;
		bcast_cmd_t cmd;
		logic [4:0] ptr;
		datagram_t [NUM_UNITS-1:0] dg;
	} st_t;
	st_t q, d;
	// device index and pointer are five bits wide
	if (DEVS > 32 || NUM_UNITS < 1 || DEVS % NUM_UNITS != 0) begin : g_bad_size
		$error("bcast_sender: bad sizing");
	end
	always_comb begin
		d = q;
		d.done = 1'b0;
		for (int u = 0; u < NUM_UNITS; u++) begin
			d.dg[u] = '0;
		end
		if (start_i && !q.busy) begin
			d.busy = 1'b1;
			d.cmd = cmd_i;
			d.ptr = 5'h00;
		end else if (q.busy && sweep_i) begin
			// one pointer shared by all units, offset per unit, one datagram per unit per sweep
			for (int u = 0; u < NUM_UNITS; u++) begin
				d.dg[u].dev = 5'(u * PER) + q.ptr;
				d.dg[u].cmd = q.cmd;
				d.dg[u].valid = logged_in_i[u * PER + int'(q.ptr)];
			end
			if (q.ptr == 5'(PER - 1)) begin
				d.busy = 1'b0;
				d.done = 1'b1;
			end else begin
				d.ptr = q.ptr + 5'h01;
			end
		end
	end
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end
	assign dgram_o = q.dg;
	assign busy_o = q.busy;
	assign done_o = q.done;
endmodule // bcast_sender
`default_nettype wire

// ---- verilog/fieldbus_diag_command_ctrl.sv ----
// Purpose: sweep-driven field-bus diagnostic command controller
// Assumes: classic wishbone slave, one clock, run mode given as a level
// Notes: events: clear done, pulse done, setup error, membership logged
// Operation
// - on clear request the fault count is zeroed before any clear datagram
// - clear datagram to each logged-in device, one per unit per sweep
// - clear request bit drops when all devices have been sent the clear
// - request bits sampled once per sweep in run mode, not while busy
// - clear and pulse together: clear is done first
// - logging bit gates recording of device add and loss as faults
// - with enable clear, routine skipped and no status or command bit written
// - enable checked every run-mode sweep, diagnostics only when set
// - pulse test bit sends pulse datagram to each logged-in device, then clears
// - setup checked on enable rising or at start in run mode; error blocks
// - overflow flag tracks count above table length each enabled run sweep
`default_nettype none
module fieldbus_diag_command_ctrl import diag_pkg::*; #(
	parameter int NUM_UNITS = 2,
	parameter int DEVS = 32,
	parameter int SWEEP_CYCLES = SWEEP_CYCLES_DEF
) (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic run_mode_i,
	input wire logic [DEVS-1:0] logged_in_i,
	output datagram_t [NUM_UNITS-1:0] dgram_o,
	output logic log_we_o,
	output logic [15:0] log_addr_o,
	output logic [4:0] log_dev_o,
	output logic log_lost_o,
	output logic irq_o
);
	typedef enum {IDLE, CLEAR_ZERO, CLEAR_SEND, PULSE_SEND} op_t;
	typedef struct packed {
		logic ack;
		logic [31:0] rdat;
		logic [3:0] ctrl;
		logic setup_err;
		logic overflow;
		logic [15:0] tbl_start;
		logic [15:0] tbl_len;
		logic [15:0] count;
		logic [EV_W-1:0] irq_stat;
		logic [EV_W-1:0] irq_mask;
		logic irq;
		logic en_prev;
		logic first;
		logic start;
		bcast_cmd_t start_cmd;
		op_t op;
		logic [DEVS-1:0] seen;
		logic run1;
		logic run2;
		logic [DEVS-1:0] sync1;
		logic [DEVS-1:0] sync2;
		logic log_we;
		logic [15:0] log_addr;
		logic [4:0] log_dev;
		logic log_lost;
	} st_t;
	st_t q, d;
	logic sweep;
	logic busy;
	logic done;
	logic wb_hit;
	logic run;
	logic [DEVS-1:0] changed;
	logic run_en;
	logic ctrl_wr;

	// device index, log device and mask read are five and 32 bits wide
	if (DEVS < 1 || DEVS > 32 || NUM_UNITS < 1 || SWEEP_CYCLES < 2) begin : g_bad_size
		$error("fieldbus_diag_command_ctrl: bad sizing");
	end

	sweep_timer #(.SWEEP_CYCLES(SWEEP_CYCLES)) u_timer (
		.core_clk_i(core_clk_i),
		.rst_n_i(rst_n_i),
		.tick_o(sweep)
	);

	bcast_sender #(.NUM_UNITS(NUM_UNITS), .DEVS(DEVS)) u_send (
		.core_clk_i(core_clk_i),
		.rst_n_i(rst_n_i),
		.start_i(q.start),
		.cmd_i(q.start_cmd),
		.sweep_i(run_en),
		.logged_in_i(q.sync2),
		.dgram_o(dgram_o),
		.busy_o(busy),
		.done_o(done)
	);

	assign wb_hit = wb_cyc_i && wb_stb_i && !q.ack;
	assign run = q.run2 && sweep;
	assign changed = q.sync2 ^ q.seen;
	// broadcasts advance only on enabled run sweeps
	assign run_en = run && q.ctrl[ENABLE_BIT] && !q.setup_err;
	assign ctrl_wr = wb_hit && wb_we_i && wb_sel_i[0] && wb_adr_i == CTRL_OFS;

	always_comb begin
		d = q;
		d.ack = wb_hit;
		d.start = 1'b0;
		d.log_we = 1'b0;
		d.run1 = run_mode_i;
		d.run2 = q.run1;
		d.sync1 = logged_in_i;
		d.sync2 = q.sync1;
		// register writes (user logic sets bits)
		if (wb_hit && wb_we_i && wb_sel_i[0]) begin
			case (wb_adr_i)
				CTRL_OFS: d.ctrl = wb_dat_i[3:0];
				TBL_START_OFS: d.tbl_start = wb_dat_i[15:0];
				TBL_LEN_OFS: d.tbl_len = wb_dat_i[15:0];
				IRQ_MASK_OFS: d.irq_mask = wb_dat_i[EV_W-1:0];
				default: d.ctrl = d.ctrl;
			endcase
		end
		// reads, interrupt status cleared on read
		d.rdat = 32'h0000_0000;
		if (wb_hit && !wb_we_i) begin
			case (wb_adr_i)
				CTRL_OFS: d.rdat = {28'h0000000, q.ctrl};
				STAT_OFS: d.rdat = {29'h0000000, busy || q.op != IDLE, q.overflow, q.setup_err};
				TBL_START_OFS: d.rdat = {16'h0000, q.tbl_start};
				TBL_LEN_OFS: d.rdat = {16'h0000, q.tbl_len};
				COUNT_OFS: d.rdat = {16'h0000, q.count};
				IRQ_STAT_OFS: d.rdat = {28'h0000000, q.irq_stat};
				IRQ_MASK_OFS: d.rdat = {28'h0000000, q.irq_mask};
				DEV_MASK_OFS: d.rdat = 32'(q.sync2);
				default: d.rdat = 32'h0000_0000;
			endcase
			if (wb_adr_i == IRQ_STAT_OFS) begin
				d.irq_stat = '0;
			end
		end
		if (run) begin
			d.en_prev = q.ctrl[ENABLE_BIT];
			d.first = 1'b0;
			// setup check on enable rising or first run sweep
			if (q.ctrl[ENABLE_BIT] && (!q.en_prev || q.first)) begin
				d.setup_err = q.tbl_len == 16'h0000 || q.tbl_len > TBL_LEN_MAX;
				if (d.setup_err) begin
					d.irq_stat[EV_SETUP_ERR] = 1'b1;
				end
			end
			// whole routine gated by enable and setup
			if (q.ctrl[ENABLE_BIT] && !d.setup_err) begin
				d.overflow = q.count > q.tbl_len;
				d.seen = q.sync2;
				// membership change logging
				if (q.ctrl[LOG_BIT] && changed != '0) begin
					for (int i = DEVS - 1; i >= 0; i--) begin
						if (changed[i]) begin
							d.log_dev = 5'(i);
							d.log_lost = !q.sync2[i];
						end
					end
					d.seen = q.seen ^ (changed & (~changed + DEVS'(1)));
					d.log_we = q.count < q.tbl_len;
					d.log_addr = q.tbl_start + (q.count * 16'h000a);
					d.count = q.count + 16'h0001;
					d.irq_stat[EV_LOGGED] = 1'b1;
				end
				case (q.op)
					IDLE: begin
						// sampled only while idle, clear first
						if (q.ctrl[CLEAR_BIT]) begin
							d.op = CLEAR_ZERO;
						end else if (q.ctrl[PULSE_BIT]) begin
							d.op = PULSE_SEND;
							d.start = 1'b1;
							d.start_cmd = CMD_PULSE;
						end
					end
					CLEAR_ZERO: begin
						d.count = 16'h0000;
						d.op = CLEAR_SEND;
						d.start = 1'b1;
						d.start_cmd = CMD_CLEAR;
					end
					default: d.op = q.op;
				endcase
			end
		end
		// completion clears request bits, set by user in same cycle wins
		if (done && q.op == CLEAR_SEND) begin
			d.op = IDLE;
			if (!ctrl_wr) begin
				d.ctrl[CLEAR_BIT] = 1'b0;
			end
			d.irq_stat[EV_CLEAR_DONE] = 1'b1;
		end
		if (done && q.op == PULSE_SEND) begin
			d.op = IDLE;
			if (!ctrl_wr) begin
				d.ctrl[PULSE_BIT] = 1'b0;
			end
			d.irq_stat[EV_PULSE_DONE] = 1'b1;
		end
		d.irq = (d.irq_stat & q.irq_mask) != '0;
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			q <= '0;
			q.first <= 1'b1;
			q.tbl_start <= TBL_START_RST;
			q.tbl_len <= TBL_LEN_RST;
			q.op <= IDLE;
			q.start_cmd <= CMD_NONE;
		end else begin
			q <= d;
		end
	end

	assign wb_ack_o = q.ack;
	assign wb_dat_o = q.rdat;
	assign irq_o = q.irq;
	assign log_we_o = q.log_we;
	assign log_addr_o = q.log_addr;
	assign log_dev_o = q.log_dev;
	assign log_lost_o = q.log_lost;
endmodule // fieldbus_diag_command_ctrl
`default_nettype wire

// ---- sim/diag_monitor.sv ----
// Purpose: port checks for the diagnostic controller
// Assumes: bench sweep period of 8 clocks
// Notes: bound to the top module
`default_nettype none
module diag_monitor import diag_pkg::*; #(
	parameter int NUM_UNITS = 2,
	parameter int DEVS = 32
) (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire datagram_t [NUM_UNITS-1:0] dgram_o,
	input wire logic log_we_o
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);
	a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held too long");
	a_ack_after_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("request not answered");
	a_ack_has_req: assert property ($rose(wb_ack_o) |-> $past(wb_stb_i))
		else $error("ack without request");
	a_dgram_cmd: assert property (dgram_o[0].valid |-> dgram_o[0].cmd != CMD_NONE)
		else $error("datagram without command");
	a_one_command: assert property (dgram_o[0].valid && dgram_o[1].valid |->
		dgram_o[0].cmd == dgram_o[1].cmd)
		else $error("two commands at once");
	a_units_split: assert property (dgram_o[0].valid && dgram_o[1].valid |->
		dgram_o[0].dev != dgram_o[1].dev)
		else $error("both units on one device");
	a_sweep_spacing: assert property (dgram_o[0].valid |=> !dgram_o[0].valid [*7])
		else $error("two datagrams in one sweep");
	a_log_spacing: assert property (log_we_o |=> !log_we_o [*7])
		else $error("two log entries in one sweep");
endmodule // diag_monitor
bind fieldbus_diag_command_ctrl diag_monitor #(.NUM_UNITS(NUM_UNITS), .DEVS(DEVS)) diag_monitor_i (
	.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_ack_o(wb_ack_o), .dgram_o(dgram_o), .log_we_o(log_we_o));
`default_nettype wire

// ---- sim/field_devs.sv ----
// Purpose: logged-in field devices taking broadcast datagrams
// Assumes: two bus interface units
// Notes: counts datagrams, flags strays and clear after pulse
`default_nettype none
module field_devs import diag_pkg::*; (
	input wire logic core_clk_i,
	input wire logic clr_i,
	input wire logic [31:0] present_i,
	input wire datagram_t [1:0] dgram_i,
	output logic [31:0] logged_in_o,
	output int n_clear,
	output int n_pulse,
	output int n_bad
);
	timeunit 1ns;
	timeprecision 1ns;
	assign logged_in_o = present_i;
	always @(posedge core_clk_i) begin
		if (clr_i) begin
			n_clear = 0;
			n_pulse = 0;
			n_bad = 0;
		end else begin
			for (int u = 0; u < 2; u++) begin
				if (dgram_i[u].valid === 1'b1) begin
					if (present_i[dgram_i[u].dev] !== 1'b1) n_bad++;
					if (dgram_i[u].cmd === CMD_CLEAR && n_pulse > 0) n_bad++;
					if (dgram_i[u].cmd === CMD_CLEAR) n_clear++;
					if (dgram_i[u].cmd === CMD_PULSE) n_pulse++;
				end
			end
		end
	end
endmodule // field_devs
`default_nettype wire

// ---- sim/tb.sv ----
// Purpose: self-checking bench for the diagnostic controller
// Assumes: sweep period shortened to 8 clocks
// Notes: registers over classic wishbone
`default_nettype none
module tb import diag_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, run = 0, clr = 0, lost = 0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'hf;
	logic [31:0] dat = 32'h0, pres = 32'hff, lin, rd, rdat;
	logic ack, lwe, llost, irq;
	logic [15:0] laddr, laddr_q;
	logic [4:0] ldev, ldev_q;
	datagram_t [1:0] dg;
	int n_fail = 0, total_checks = 0, ncl, npu, nbad, nlog = 0, cycles = 0;
	fieldbus_diag_command_ctrl #(.SWEEP_CYCLES(8)) fieldbus_diag_command_ctrl_i (
		.core_clk_i(clk), .rst_n_i(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rd), .wb_ack_o(ack),
		.run_mode_i(run), .logged_in_i(lin), .dgram_o(dg), .log_we_o(lwe),
		.log_addr_o(laddr), .log_dev_o(ldev), .log_lost_o(llost), .irq_o(irq));
	field_devs field_devs_i (.core_clk_i(clk), .clr_i(clr), .present_i(pres), .dgram_i(dg),
		.logged_in_o(lin), .n_clear(ncl), .n_pulse(npu), .n_bad(nbad));
	initial forever #25 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (lwe === 1'b1) begin
			nlog++;
			lost = llost;
			laddr_q = laddr;
			ldev_q = ldev;
		end
		if (cycles == 5000) begin
			n_fail++;
			end_sim();
		end
	end
	task automatic end_sim();
		$display("checks %0d fails %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		do @(posedge clk); while (ack !== 1'b1);
		rdat = rd;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task automatic t_regs();
		wb(1'b0, TBL_LEN_OFS, 32'h0);
		chk(rdat, 32'h0);
		wb(1'b1, 8'h20, 32'hffff_ffff);
		wb(1'b0, 8'h20, 32'h0);
		chk(rdat, 32'h0);
		$display("test regs done");
	endtask
	task automatic t_setup();
		wb(1'b1, IRQ_MASK_OFS, 32'h1 << EV_SETUP_ERR);
		wb(1'b1, CTRL_OFS, 32'h1 << ENABLE_BIT);
		repeat (24) @(posedge clk);
		chk(32'(irq), 32'h1);
		wb(1'b0, STAT_OFS, 32'h0);
		chk(32'(rdat[SETUP_ERR_BIT]), 32'h1);
		wb(1'b0, IRQ_STAT_OFS, 32'h0);
		chk(rdat, 32'h1 << EV_SETUP_ERR);
		repeat (2) @(posedge clk);
		chk(32'(irq), 32'h0);
		wb(1'b1, TBL_LEN_OFS, 32'h10);
		wb(1'b1, CTRL_OFS, 32'h0);
		repeat (16) @(posedge clk);
		wb(1'b1, CTRL_OFS, 32'h1 << ENABLE_BIT);
		repeat (24) @(posedge clk);
		wb(1'b0, STAT_OFS, 32'h0);
		chk(32'(rdat[SETUP_ERR_BIT]), 32'h0);
		$display("test setup done");
	endtask
	task automatic t_off();
		wb(1'b1, CTRL_OFS, 32'h1 << CLEAR_BIT);
		repeat (32) @(posedge clk);
		wb(1'b0, CTRL_OFS, 32'h0);
		chk(rdat, 32'h1 << CLEAR_BIT);
		chk(32'(ncl), 32'h0);
		wb(1'b1, CTRL_OFS, 32'h0);
		$display("test disabled done");
	endtask
	task automatic t_log();
		wb(1'b1, CTRL_OFS, 32'hc);
		pres <= 32'hfe;
		repeat (32) @(posedge clk);
		wb(1'b1, CTRL_OFS, 32'h8);
		pres <= 32'hff;
		repeat (32) @(posedge clk);
		chk(32'(nlog), 32'h1);
		chk(32'(lost), 32'h1);
		wb(1'b1, CTRL_OFS, 32'hc);
		pres <= 32'hfd;
		repeat (32) @(posedge clk);
		chk(32'(nlog), 32'h2);
		chk(32'(laddr_q), 32'ha);
		chk(32'(ldev_q), 32'h1);
		wb(1'b0, COUNT_OFS, 32'h0);
		chk(rdat, 32'h2);
		wb(1'b1, TBL_LEN_OFS, 32'h1);
		repeat (24) @(posedge clk);
		wb(1'b0, STAT_OFS, 32'h0);
		chk(32'(rdat[OVERFLOW_BIT]), 32'h1);
		$display("test logging done");
	endtask
	task automatic t_both();
		clr <= 1'b1;
		@(posedge clk);
		clr <= 1'b0;
		wb(1'b1, CTRL_OFS, 32'hb);
		repeat (16) @(posedge clk);
		wb(1'b0, STAT_OFS, 32'h0);
		chk(32'(rdat[BUSY_BIT]), 32'h1);
		for (int i = 0; i < 100; i++) begin
			wb(1'b0, CTRL_OFS, 32'h0);
			if (rdat[1:0] === 2'b00) break;
			repeat (8) @(posedge clk);
		end
		chk(32'(rdat[1:0]), 32'h0);
		chk(32'(ncl), 32'h7);
		chk(32'(npu), 32'h7);
		chk(32'(nbad), 32'h0);
		wb(1'b0, COUNT_OFS, 32'h0);
		chk(rdat, 32'h0);
		wb(1'b0, STAT_OFS, 32'h0);
		chk(32'(rdat[OVERFLOW_BIT]), 32'h0);
		chk(32'(rdat[BUSY_BIT]), 32'h0);
		$display("test broadcast done");
	endtask
	initial begin
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		run <= 1'b1;
		t_regs();
		t_setup();
		t_off();
		t_log();
		t_both();
		end_sim();
	end
endmodule // tb
`default_nettype wire
